// *** verilog/tob_pkg.sv ***
// constants, register map and types of the thermal stage supervision
// assumes a 100 MHz clock and a 1 ms processing cycle
package tob_pkg;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ        = 100;
  localparam int PROC_CYCLE_US  = 1000;
  localparam int PROC_CYCLE_CYC = PROC_CYCLE_US * CLK_MHZ;
  localparam int DIV_W          = 17;
  localparam int BLOCK_LEAD_MS  = 5;      // far side lead on block input

  // ----------------------------------------------------------------------
  // scales: current in 0.01 x In, capacity in 0.1 %, factors in 0.01
  // ----------------------------------------------------------------------
  localparam logic [15:0] CUR_LIGHT    = 16'h0001;  // 1 % of In
  localparam logic [15:0] CUR_TWICE_IN = 16'h00C8;  // 2 x In
  localparam logic [8:0]  FACTOR_ONE   = 9'h064;    // 1.0
  localparam logic [8:0]  FACTOR_MIN   = 9'h001;    // 0.01
  localparam logic [8:0]  FACTOR_MAX   = 9'h1F4;    // 5.00
  localparam logic [15:0] INOM_ONE     = 16'h0064;  // 1.0
  localparam logic [23:0] TTF_NEVER    = 24'hFFFFFF;

  // ----------------------------------------------------------------------
  // register map (word index) and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_A1_LVL   = 8'h01;
  localparam logic [7:0] REG_A2_LVL   = 8'h02;
  localparam logic [7:0] REG_INH_LVL  = 8'h03;
  localparam logic [7:0] REG_TRIP_LVL = 8'h04;
  localparam logic [7:0] REG_TRIP_DLY = 8'h05;
  localparam logic [7:0] REG_SF       = 8'h06;
  localparam logic [7:0] REG_KMIN     = 8'h07;
  localparam logic [7:0] REG_KMAX     = 8'h08;
  localparam logic [7:0] REG_INOM     = 8'h09;
  localparam logic [7:0] REG_STATUS   = 8'h0A;
  localparam logic [7:0] REG_TRIP_REM = 8'h0B;
  localparam logic [7:0] REG_CNT_BASE = 8'h0C;  // five counters
  localparam logic [7:0] REG_CNT_CLR  = 8'h11;

  localparam logic [10:0] A1_LVL_RST   = 11'h190;  // 40 %
  localparam logic [10:0] A2_LVL_RST   = 11'h190;  // 40 %
  localparam logic [10:0] INH_LVL_RST  = 11'h320;  // 80 %
  localparam logic [10:0] TRIP_LVL_RST = 11'h3E8;  // 100 %
  localparam logic [21:0] TRIP_DLY_RST = 22'h000000;

  localparam int NCNT    = 5;
  localparam int CNT_W   = 16;
  localparam int CNT_A1  = 0;
  localparam int CNT_A2  = 1;
  localparam int CNT_INH = 2;
  localparam int CNT_TRP = 3;
  localparam int CNT_BLK = 4;

  typedef enum logic [2:0] {
    TOB_NORMAL, TOB_ALARM1, TOB_ALARM2, TOB_INHIBIT, TOB_TRIP, TOB_BLOCKED
  } tob_cond_t;

  typedef enum logic [1:0] {
    TOB_LIGHT, TOB_LOAD_NORMAL, TOB_OVERLOAD, TOB_HIGH_OVERLOAD
  } tob_tstat_t;
endpackage : tob_pkg

// *** verilog/tob_thermal_stage.sv ***
// supervision of a thermal overload stage: block handling, output levels,
// load classification, setting checks, timing readback, activation counters
// assumes pick-up, capacity and timing inputs come from logic on clk and
// block_in comes from outside the clock domain
//
// How it works
// - block input sampled once per processing cycle
// - pick-up while unblocked raises start, times trip
// - pick-up while blocked raises blocked, nothing more
// - block during start drops start, releases timing
// - condition has six values; normal drives nothing
// - light load when current below 1 % In
// - load normal up to trip limit otherwise
// - overloading up to 2 In, high overload above
// - bad service factor flags, uses 1.0
// - bad ambient settings flag, use 1.0
// - bad nominal current flags, uses 1.0
// - inconsistent ambient k raises separate flag
// - active current is largest phase rms
// - trip expected indicator, two values
// - remaining trip delay is time to full
// - separate counters for both alarm outputs
// - counter for restart inhibit activations
// - count trips and blocked trips separately
// - enabled thresholds drive alarm, inhibit, trip
// - extra trip delay, zero adds none
`timescale 1ns/1ns
module tob_thermal_stage #(
  parameter int PROC_CYCLE_CYC = tob_pkg::PROC_CYCLE_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // pick-up element, blocking matrix, thermal image
  input  wire logic        pickup,
  input  wire logic        block_in,
  input  wire logic [10:0] theta,
  input  wire logic [15:0] phase_a_current,
  input  wire logic [15:0] phase_b_current,
  input  wire logic [15:0] phase_c_current,
  input  wire logic [15:0] equivalent_reference_current,
  input  wire logic [23:0] time_to_full,
  // output controls
  output logic             start,
  output logic             blocked,
  output logic             alarm1,
  output logic             alarm2,
  output logic             inhibit,
  output logic             trip,
  // status
  output logic [2:0]       condition,
  output logic [1:0]       thermal_status,
  output logic [15:0]      active_current,
  output logic             trip_expected,
  output logic [23:0]      trip_delay_rem,
  output logic             sf_fault,
  output logic             amb_fault,
  output logic             inom_fault,
  output logic             amb_k_inconsistent,
  output logic [8:0]       service_factor_used,
  output logic [8:0]       amb_k_min_used,
  output logic [8:0]       amb_k_max_used,
  output logic [15:0]      inom_used
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                              blk_s1;
    logic                              blk_s2;
    logic [tob_pkg::DIV_W-1:0]         div;
    logic                              blk_cyc;
    logic                              pu_prev;
    logic                              start;
    logic                              blocked;
    logic [21:0]                       dly;
    logic                              a1;
    logic                              a2;
    logic                              inh;
    logic                              trip;
    logic                              trip_blk;
    logic [tob_pkg::NCNT-1:0]          ev_prev;
    logic [tob_pkg::NCNT-1:0][tob_pkg::CNT_W-1:0] cnt;
    logic [3:0]                        en;
    logic [10:0]                       a1_lvl;
    logic [10:0]                       a2_lvl;
    logic [10:0]                       inh_lvl;
    logic [10:0]                       trip_lvl;
    logic [21:0]                       trip_dly;
    logic [8:0]                        sf;
    logic [8:0]                        kmin;
    logic [8:0]                        kmax;
    logic [15:0]                       inom;
    logic [15:0]                       imax;
    tob_pkg::tob_tstat_t               tstat;
    tob_pkg::tob_cond_t                cond;
    logic                              texp;
    logic [23:0]                       trem;
    logic                              sf_f;
    logic                              amb_f;
    logic                              inom_f;
    logic                              kinc;
    logic [31:0]                       rdata;
  } tob_state_t;

  tob_state_t s_r;
  tob_state_t s_nxt;

  logic                     tick;
  logic                     trip_cond;
  logic [15:0]              imax;
  logic [tob_pkg::NCNT-1:0] ev;
  logic [tob_pkg::NCNT-1:0] rise;
  logic [tob_pkg::NCNT-1:0] clr;
  logic                     sf_bad;
  logic                     kmin_bad;
  logic                     kmax_bad;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // block input crosses in through two flops
    s_nxt.blk_s1 = block_in;
    s_nxt.blk_s2 = s_r.blk_s1;

    // processing cycle enable
    tick = (s_r.div == tob_pkg::DIV_W'(PROC_CYCLE_CYC - 1));
    s_nxt.div = tick ? '0 : s_r.div + 1'b1;

    // largest of the three phase rms values
    imax = phase_a_current;
    if (phase_b_current > imax) begin
      imax = phase_b_current;
    end
    if (phase_c_current > imax) begin
      imax = phase_c_current;
    end
    s_nxt.imax = imax;

    // load classification, checked from the top down
    if (imax > tob_pkg::CUR_TWICE_IN) begin
      s_nxt.tstat = tob_pkg::TOB_HIGH_OVERLOAD;
    end else if (imax > equivalent_reference_current) begin
      s_nxt.tstat = tob_pkg::TOB_OVERLOAD;
    end else if (imax < tob_pkg::CUR_LIGHT) begin
      s_nxt.tstat = tob_pkg::TOB_LIGHT;
    end else begin
      s_nxt.tstat = tob_pkg::TOB_LOAD_NORMAL;
    end

    // setting checks; flags exist only while the fault does
    sf_bad   = (s_r.sf < tob_pkg::FACTOR_MIN) ||
               (s_r.sf > tob_pkg::FACTOR_MAX);
    kmin_bad = (s_r.kmin < tob_pkg::FACTOR_MIN) ||
               (s_r.kmin > tob_pkg::FACTOR_MAX);
    kmax_bad = (s_r.kmax < tob_pkg::FACTOR_MIN) ||
               (s_r.kmax > tob_pkg::FACTOR_MAX);
    s_nxt.sf_f   = sf_bad;
    s_nxt.amb_f  = kmin_bad || kmax_bad;
    s_nxt.inom_f = (s_r.inom == '0);
    s_nxt.kinc   = (s_r.kmin > s_r.kmax);

    // timing readback from the thermal image
    s_nxt.trem = time_to_full;
    s_nxt.texp = (time_to_full != tob_pkg::TTF_NEVER);

    // trip level reached and enabled
    trip_cond = s_r.en[3] && (theta >= s_r.trip_lvl);

    // once per processing cycle: block, start and output decisions
    if (tick) begin
      s_nxt.blk_cyc = s_r.blk_s2;
      s_nxt.pu_prev = pickup;
      if (pickup && !s_r.pu_prev) begin
        s_nxt.start   = !s_nxt.blk_cyc;
        s_nxt.blocked = s_nxt.blk_cyc;
      end
      if (!pickup) begin
        s_nxt.start   = 1'b0;
        s_nxt.blocked = 1'b0;
      end
      if (s_r.start && s_nxt.blk_cyc) begin
        s_nxt.start = 1'b0;
      end
      // extra trip delay counted in processing cycles; released with start
      if (s_nxt.start && trip_cond) begin
        if (s_r.dly != s_r.trip_dly) begin
          s_nxt.dly = s_r.dly + 1'b1;
        end
      end else begin
        s_nxt.dly = '0;
      end
      s_nxt.trip = s_nxt.start && trip_cond &&
                   (s_r.dly == s_r.trip_dly);
      s_nxt.trip_blk = s_nxt.blocked && trip_cond;
      s_nxt.a1  = s_r.en[0] && (theta >= s_r.a1_lvl);
      s_nxt.a2  = s_r.en[1] && (theta >= s_r.a2_lvl);
      s_nxt.inh = s_r.en[2] && (theta >= s_r.inh_lvl);
    end

    // condition: blocked outranks every output
    if (s_r.blocked) begin
      s_nxt.cond = tob_pkg::TOB_BLOCKED;
    end else if (s_r.trip) begin
      s_nxt.cond = tob_pkg::TOB_TRIP;
    end else if (s_r.inh) begin
      s_nxt.cond = tob_pkg::TOB_INHIBIT;
    end else if (s_r.a2) begin
      s_nxt.cond = tob_pkg::TOB_ALARM2;
    end else if (s_r.a1) begin
      s_nxt.cond = tob_pkg::TOB_ALARM1;
    end else begin
      s_nxt.cond = tob_pkg::TOB_NORMAL;
    end

    // register writes
    clr = '0;
    if (wr) begin
      if (addr == tob_pkg::REG_CTRL) begin
        s_nxt.en = wdata[3:0];
      end else if (addr == tob_pkg::REG_A1_LVL) begin
        s_nxt.a1_lvl = wdata[10:0];
      end else if (addr == tob_pkg::REG_A2_LVL) begin
        s_nxt.a2_lvl = wdata[10:0];
      end else if (addr == tob_pkg::REG_INH_LVL) begin
        s_nxt.inh_lvl = wdata[10:0];
      end else if (addr == tob_pkg::REG_TRIP_LVL) begin
        s_nxt.trip_lvl = wdata[10:0];
      end else if (addr == tob_pkg::REG_TRIP_DLY) begin
        s_nxt.trip_dly = wdata[21:0];
      end else if (addr == tob_pkg::REG_SF) begin
        s_nxt.sf = wdata[8:0];
      end else if (addr == tob_pkg::REG_KMIN) begin
        s_nxt.kmin = wdata[8:0];
      end else if (addr == tob_pkg::REG_KMAX) begin
        s_nxt.kmax = wdata[8:0];
      end else if (addr == tob_pkg::REG_INOM) begin
        s_nxt.inom = wdata[15:0];
      end else if (addr == tob_pkg::REG_CNT_CLR) begin
        clr = wdata[tob_pkg::NCNT-1:0];
      end
    end

    // activation counters; a rise in the clear cycle still counts
    ev = '0;
    ev[tob_pkg::CNT_A1]  = s_r.a1;
    ev[tob_pkg::CNT_A2]  = s_r.a2;
    ev[tob_pkg::CNT_INH] = s_r.inh;
    ev[tob_pkg::CNT_TRP] = s_r.trip;
    ev[tob_pkg::CNT_BLK] = s_r.trip_blk;
    rise = ev & ~s_r.ev_prev;
    s_nxt.ev_prev = ev;
    for (int i = 0; i < tob_pkg::NCNT; i++) begin
      if (clr[i]) begin
        s_nxt.cnt[i] = '0;
      end
      if (rise[i]) begin
        s_nxt.cnt[i] = clr[i] ? tob_pkg::CNT_W'(1)
                              : s_r.cnt[i] + 1'b1;
      end
    end

    // register reads, answered in the next cycle; unmapped reads zero
    s_nxt.rdata = '0;
    if (rd) begin
      if (addr == tob_pkg::REG_CTRL) begin
        s_nxt.rdata = {28'h0000000, s_r.en};
      end else if (addr == tob_pkg::REG_A1_LVL) begin
        s_nxt.rdata = {21'h000000, s_r.a1_lvl};
      end else if (addr == tob_pkg::REG_A2_LVL) begin
        s_nxt.rdata = {21'h000000, s_r.a2_lvl};
      end else if (addr == tob_pkg::REG_INH_LVL) begin
        s_nxt.rdata = {21'h000000, s_r.inh_lvl};
      end else if (addr == tob_pkg::REG_TRIP_LVL) begin
        s_nxt.rdata = {21'h000000, s_r.trip_lvl};
      end else if (addr == tob_pkg::REG_TRIP_DLY) begin
        s_nxt.rdata = {10'h000, s_r.trip_dly};
      end else if (addr == tob_pkg::REG_SF) begin
        s_nxt.rdata = {23'h000000, s_r.sf};
      end else if (addr == tob_pkg::REG_KMIN) begin
        s_nxt.rdata = {23'h000000, s_r.kmin};
      end else if (addr == tob_pkg::REG_KMAX) begin
        s_nxt.rdata = {23'h000000, s_r.kmax};
      end else if (addr == tob_pkg::REG_INOM) begin
        s_nxt.rdata = {16'h0000, s_r.inom};
      end else if (addr == tob_pkg::REG_STATUS) begin
        s_nxt.rdata = {16'h0000, s_r.kinc, s_r.inom_f, s_r.amb_f,
                       s_r.sf_f, s_r.texp, s_r.blocked, s_r.start,
                       s_r.trip, s_r.inh, s_r.a2, s_r.a1,
                       s_r.tstat, s_r.cond};
      end else if (addr == tob_pkg::REG_TRIP_REM) begin
        s_nxt.rdata = {8'h00, s_r.trem};
      end else if ((addr >= tob_pkg::REG_CNT_BASE) &&
                   (addr < tob_pkg::REG_CNT_CLR)) begin
        s_nxt.rdata = {16'h0000,
                       s_r.cnt[3'(addr - tob_pkg::REG_CNT_BASE)]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers; settings reset to their defaults
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r          <= '0;
      s_r.a1_lvl   <= tob_pkg::A1_LVL_RST;
      s_r.a2_lvl   <= tob_pkg::A2_LVL_RST;
      s_r.inh_lvl  <= tob_pkg::INH_LVL_RST;
      s_r.trip_lvl <= tob_pkg::TRIP_LVL_RST;
      s_r.trip_dly <= tob_pkg::TRIP_DLY_RST;
      s_r.sf       <= tob_pkg::FACTOR_ONE;
      s_r.kmin     <= tob_pkg::FACTOR_ONE;
      s_r.kmax     <= tob_pkg::FACTOR_ONE;
      s_r.inom     <= tob_pkg::INOM_ONE;
      s_r.trem     <= tob_pkg::TTF_NEVER;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------------
  assign rdata              = s_r.rdata;
  assign start              = s_r.start;
  assign blocked            = s_r.blocked;
  assign alarm1             = s_r.a1;
  assign alarm2             = s_r.a2;
  assign inhibit            = s_r.inh;
  assign trip               = s_r.trip;
  assign condition          = s_r.cond;
  assign thermal_status     = s_r.tstat;
  assign active_current     = s_r.imax;
  assign trip_expected      = s_r.texp;
  assign trip_delay_rem     = s_r.trem;
  assign sf_fault           = s_r.sf_f;
  assign amb_fault          = s_r.amb_f;
  assign inom_fault         = s_r.inom_f;
  assign amb_k_inconsistent = s_r.kinc;
  // faulty settings fall back to 1.0; inconsistent k has no fallback
  assign service_factor_used = s_r.sf_f ? tob_pkg::FACTOR_ONE
                                        : s_r.sf;
  assign amb_k_min_used = s_r.amb_f ? tob_pkg::FACTOR_ONE
                                    : s_r.kmin;
  assign amb_k_max_used = s_r.amb_f ? tob_pkg::FACTOR_ONE
                                    : s_r.kmax;
  assign inom_used = s_r.inom_f ? tob_pkg::INOM_ONE
                                : s_r.inom;
endmodule : tob_thermal_stage

// *** verification/tob_thermal_stage_sva.sv ***
// port assertions for the thermal stage supervision
// assumes a bind from the bench top onto tob_thermal_stage
`timescale 1ns/1ns
module tob_thermal_stage_sva #(
  parameter int PROC_CYCLE_CYC = 20
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // measured inputs
  input wire logic [15:0] phase_a_current,
  input wire logic [15:0] phase_b_current,
  input wire logic [15:0] phase_c_current,
  input wire logic [23:0] time_to_full,
  // output controls
  input wire logic        start,
  input wire logic        blocked,
  input wire logic        alarm1,
  input wire logic        alarm2,
  input wire logic        inhibit,
  input wire logic        trip,
  // status
  input wire logic [2:0]  condition,
  input wire logic [15:0] active_current,
  input wire logic        trip_expected,
  input wire logic [23:0] trip_delay_rem,
  input wire logic        sf_fault,
  input wire logic        amb_fault,
  input wire logic        inom_fault,
  input wire logic [8:0]  service_factor_used,
  input wire logic [8:0]  amb_k_min_used,
  input wire logic [8:0]  amb_k_max_used,
  input wire logic [15:0] inom_used
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] cur_max;

  // largest phase, the figure the stage must carry one clock later
  always_comb begin
    cur_max = phase_a_current;
    if (phase_b_current > cur_max) cur_max = phase_b_current;
    if (phase_c_current > cur_max) cur_max = phase_c_current;
  end

  // named steps
  sequence s_quiet;
    !(alarm1 || alarm2 || inhibit || trip || blocked);
  endsequence
  sequence s_start_drop;
    start ##1 !start;
  endsequence

  property p_excl;     !(start && blocked); endproperty
  property p_trip_st;  trip |-> start; endproperty
  property p_release;  s_start_drop |-> !blocked; endproperty
  property p_norm;
    s_quiet ##1 s_quiet |-> condition == tob_pkg::TOB_NORMAL;
  endproperty
  property p_cond_trip;
    condition == tob_pkg::TOB_TRIP |-> $past(trip);
  endproperty
  property p_cur;
    !$past(rst) |-> active_current == $past(cur_max);
  endproperty
  property p_texp;
    !$past(rst) |-> trip_expected == ($past(time_to_full) != 24'hFFFFFF);
  endproperty
  property p_trem;
    !$past(rst) |-> trip_delay_rem == $past(time_to_full);
  endproperty
  property p_sf;  sf_fault |-> service_factor_used == 9'h064; endproperty
  property p_amb;
    amb_fault |-> amb_k_min_used == 9'h064 && amb_k_max_used == 9'h064;
  endproperty
  property p_inom; inom_fault |-> inom_used == 16'h0064; endproperty

  a_excl:      assert property (p_excl) else $error("start with blocked");
  a_trip_st:   assert property (p_trip_st) else $error("trip no start");
  a_release:   assert property (p_release) else $error("blocked on drop");
  a_norm:      assert property (p_norm) else $error("not normal");
  a_cond_trip: assert property (p_cond_trip) else $error("cond trip");
  a_cur:       assert property (p_cur) else $error("active current");
  a_texp:      assert property (p_texp) else $error("trip expected");
  a_trem:      assert property (p_trem) else $error("delay remaining");
  a_sf:        assert property (p_sf) else $error("service factor");
  a_amb:       assert property (p_amb) else $error("ambient factor");
  a_inom:      assert property (p_inom) else $error("nominal current");
endmodule : tob_thermal_stage_sva

// *** verification/tob_far_side.sv ***
// pick-up element, blocking matrix and thermal image feed
// assumes the bench calls its tasks from a process on clk
`timescale 1ns/1ns
module tob_far_side (
  // clock
  input  wire logic        clk,
  // toward the stage
  output logic             pickup,
  output logic             block_in,
  output logic      [10:0] theta,
  output logic      [23:0] time_to_full
);
  // idle: no pick-up, no block, cold image, no trip foreseen
  initial begin
    pickup       = 1'b0;
    block_in     = 1'b0;
    theta        = 11'h000;
    time_to_full = 24'hFFFFFF;
  end

  // pick-up, block and capacity change together, on the first edge after the call
  task automatic drive(input logic p, input logic b, input logic [10:0] th);
    @(posedge clk);
    pickup   <= p;
    block_in <= b;
    theta    <= th;
  endtask : drive

  task automatic set_ttf(input logic [23:0] t);
    @(posedge clk);
    time_to_full <= t;
  endtask : set_ttf
endmodule : tob_far_side

// *** verification/tb_tob_thermal_stage.sv ***
// self-checking bench of the thermal stage supervision
// assumes tob_pkg, the stage, the far side model and the checker
`timescale 1ns/1ns
module tb_tob_thermal_stage;
  localparam int P = 20;  // short processing cycle, brief run
  logic        clk, rst, wr, rd, pickup, block_in;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [10:0] theta;
  logic [15:0] phase_a_current, phase_b_current, phase_c_current;
  logic [15:0] equivalent_reference_current, active_current, inom_used;
  logic [23:0] time_to_full, trip_delay_rem;
  logic        start, blocked, alarm1, alarm2, inhibit, trip, trip_expected;
  logic        sf_fault, amb_fault, inom_fault, amb_k_inconsistent;
  logic [2:0]  condition;
  logic [1:0]  thermal_status;
  logic [8:0]  service_factor_used, amb_k_min_used, amb_k_max_used;
  int          miscompares = 0;
  int          checks = 0;

  tob_thermal_stage #(.PROC_CYCLE_CYC(P)) tob_thermal_stage_i (
    .clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .pickup, .block_in,
    .theta, .phase_a_current, .phase_b_current, .phase_c_current,
    .equivalent_reference_current, .time_to_full, .start, .blocked,
    .alarm1, .alarm2, .inhibit, .trip, .condition, .thermal_status,
    .active_current, .trip_expected, .trip_delay_rem, .sf_fault,
    .amb_fault, .inom_fault, .amb_k_inconsistent, .service_factor_used,
    .amb_k_min_used, .amb_k_max_used, .inom_used);
  tob_far_side tob_far_side_i (.clk, .pickup, .block_in, .theta,
    .time_to_full);

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one-cycle strobes, changed right after an edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    chk($sformatf("reg %h", a), d, exp);
  endtask : chk_reg

  task automatic ticks(input int n);
    repeat (n * P) @(posedge clk);
    #1;
  endtask : ticks

  task automatic t_regs();
    logic [7:0]  ra [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06};
    logic [31:0] rv [6] = '{32'h0, 32'h190, 32'h190, 32'h320, 32'h3E8,
                            32'h64};
    for (int i = 0; i < 6; i++)
      chk_reg(ra[i], rv[i]);
    wr_reg(8'h05, 32'h5);
    chk_reg(8'h05, 32'h5);
    wr_reg(8'h05, 32'h0);
    wr_reg(8'h0B, 32'h0);
    chk_reg(8'h0B, 32'hFFFFFF);
    chk_reg(8'hFF, 32'h0);
  endtask : t_regs

  task automatic t_load();
    logic [15:0] cv [6] = '{16'h0000, 16'h0001, 16'h0050, 16'h0096,
                            16'h00C8, 16'h00C9};
    logic [1:0]  es [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      phase_a_current <= (i % 3 == 0) ? cv[i] : cv[i] >> 1;
      phase_b_current <= (i % 3 == 1) ? cv[i] : cv[i] >> 1;
      phase_c_current <= (i % 3 == 2) ? cv[i] : cv[i] >> 1;
      repeat (4) @(posedge clk);
      #1;
      chk("active current", active_current, cv[i]);
      chk("thermal status", thermal_status, es[i]);
    end
  endtask : t_load

  // bad service factor, k max and nominal current, an inconsistent k min, each repair, and the value used
  task automatic t_faults();
    logic [7:0]  fa [10] = '{8'h06, 8'h06, 8'h06, 8'h06, 8'h08, 8'h08,
                             8'h07, 8'h07, 8'h09, 8'h09};
    logic [15:0] fd [10] = '{16'h0000, 16'h0096, 16'h01F5, 16'h0064,
                             16'h01F6, 16'h0064, 16'h012C, 16'h0064,
                             16'h0000, 16'h0064};
    logic [3:0]  ff [10] = '{4'h1, 4'h0, 4'h1, 4'h0, 4'h2, 4'h0, 4'h8,
                             4'h0, 4'h4, 4'h0};
    logic [15:0] used;
    for (int i = 0; i < 10; i++) begin
      wr_reg(fa[i], {16'h0000, fd[i]});
      repeat (3) @(posedge clk);
      #1;
      chk("fault flags", {amb_k_inconsistent, inom_fault, amb_fault,
          sf_fault}, ff[i]);
      case (fa[i])
        8'h06:   used = {7'h00, service_factor_used};
        8'h07:   used = {7'h00, amb_k_min_used};
        8'h08:   used = {7'h00, amb_k_max_used};
        default: used = inom_used;
      endcase
      chk("used", used, (ff[i][2:0] != 0) ? 16'h64 : fd[i]);
    end
  endtask : t_faults

  task automatic t_trip();
    wr_reg(8'h00, 32'h8);
    tob_far_side_i.drive(1'b1, 1'b0, 11'h3E8);
    ticks(2);
    chk("start trip", {start, trip, condition}, 5'h1C);
    chk_reg(8'h0F, 32'h1);
    tob_far_side_i.drive(1'b1, 1'b1, 11'h3E8);
    ticks(2);
    chk("start blocked trip", {start, blocked, trip}, 3'h0);
    tob_far_side_i.drive(1'b0, 1'b1, 11'h3E8);
    ticks(2);
    tob_far_side_i.drive(1'b1, 1'b1, 11'h3E8);
    ticks(2);
    chk("blocked", {start, blocked, trip, condition}, 6'h15);
    chk_reg(8'h10, 32'h1);
    chk_reg(8'h0F, 32'h1);
    tob_far_side_i.drive(1'b0, 1'b0, 11'h000);
    ticks(2);
  endtask : t_trip

  task automatic t_delay();
    int n = 0;
    wr_reg(8'h05, 32'h3);
    tob_far_side_i.drive(1'b1, 1'b0, 11'h3E8);
    while (start !== 1'b1 && n < 3 * P) begin
      @(posedge clk);
      #1 n++;
    end
    chk("start", start, 1'b1);
    chk("early trip", trip, 1'b0);
    ticks(2);
    chk("early trip", trip, 1'b0);
    ticks(2);
    chk("late trip", trip, 1'b1);
    chk_reg(8'h0F, 32'h2);
    wr_reg(8'h11, 32'h8);
    chk_reg(8'h0F, 32'h0);
    chk_reg(8'h10, 32'h1);
    tob_far_side_i.drive(1'b0, 1'b0, 11'h000);
    wr_reg(8'h05, 32'h0);
    ticks(2);
  endtask : t_delay

  // alarm one, alarm two, inhibit in turn, each enabled alone
  task automatic t_alarms();
    for (int i = 0; i < 3; i++) begin
      wr_reg(8'h00, 32'h1 << i);
      tob_far_side_i.drive(1'b0, 1'b0, 11'h384);
      ticks(2);
      chk("condition", condition, i + 1);
      chk_reg(8'h0C + i, 32'h1);
      ticks(1);
      chk_reg(8'h0C + i, 32'h1);
      tob_far_side_i.drive(1'b0, 1'b0, 11'h000);
      ticks(2);
      chk("quiet", {condition, alarm1, alarm2, inhibit}, 6'h0);
    end
    tob_far_side_i.set_ttf(24'h0004D2);
    repeat (3) @(posedge clk);
    #1;
    chk("ttf", {trip_expected, trip_delay_rem}, 25'h10004D2);
  endtask : t_alarms

  task automatic test_done();
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // main sequence
  initial begin
    {rst, wr, rd, addr, wdata} = {1'b1, 42'h0};
    {phase_a_current, phase_b_current, phase_c_current} = 48'h0;
    equivalent_reference_current = 16'h006E;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_load();
    t_faults();
    t_trip();
    t_delay();
    t_alarms();
    test_done();
  end

  // run needs about 800 cycles; a hang ends here
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule : tb_tob_thermal_stage

bind tob_thermal_stage tob_thermal_stage_sva #(
  .PROC_CYCLE_CYC(PROC_CYCLE_CYC)) tob_thermal_stage_sva_i (
  .clk, .rst, .phase_a_current, .phase_b_current, .phase_c_current,
  .time_to_full, .start, .blocked, .alarm1, .alarm2, .inhibit, .trip,
  .condition, .active_current, .trip_expected, .trip_delay_rem, .sf_fault,
  .amb_fault, .inom_fault, .service_factor_used, .amb_k_min_used,
  .amb_k_max_used, .inom_used);
